// >>> idw_host_model.sv
// Purpose: host side that fetches identification words one at a time
// Assumes: one strobe per word, answer within a few cycles
// Notes: index shows the inverse of the last value while idle
module idw_host_model (
  // clock
  input wire logic clk,
  // read port
  output logic rd_strobe,
  output logic [7:0] rd_index,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    rd_strobe = 1'b0;
    rd_index = 8'hFF;
  end

  // one data-port fetch; ok stays low if no answer comes
  task automatic read_word(input logic [7:0] idx, output logic [15:0] data, output bit ok);
    ok = 1'b0;
    data = 'x;
    @(posedge clk);
    rd_strobe <= 1'b1;
    rd_index <= idx;
    @(posedge clk);
    rd_strobe <= 1'b0;
    rd_index <= ~idx;
    for (int k = 0; k < 4 && !ok; k++) begin
      #1;
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        data = rd_data;
      end else begin
        @(posedge clk);
      end
    end
  endtask
endmodule // idw_host_model

// >>> idw_onehot.sv
// Purpose: keeps at most one bit of a mode vector set
// Assumes: lowest set bit wins when several are requested
// Notes: combinational
module idw_onehot #(
  parameter int N = 7
) (
  // vectors
  input wire logic [N-1:0] req,
  output logic [N-1:0] sel
);
  always_comb begin
    sel = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        sel = '0;
        sel[i] = 1'b1;
      end
    end
  end
endmodule // idw_onehot

// >>> idw_pkg.sv
// Purpose: constants for the upper identification words (87..254) and the reset-result word
// Assumes: 16-bit words, word index 0..255, single 25 MHz clock
// Notes: word 255 and words below 87 are produced elsewhere
package idw_pkg;
  localparam logic [7:0] IDW_W_DEFAULT = 8'h57;
  localparam logic [7:0] IDW_W_UDMA = 8'h58;
  localparam logic [7:0] IDW_W_RESET = 8'h5D;
  localparam logic [7:0] IDW_W_ACOUSTIC = 8'h5E;
  localparam logic [7:0] IDW_W_SECTOR = 8'h6A;
  localparam logic [7:0] IDW_W_WWN0 = 8'h6C;
  localparam logic [7:0] IDW_W_WWN1 = 8'h6D;
  localparam logic [7:0] IDW_W_WWN2 = 8'h6E;
  localparam logic [7:0] IDW_W_WWN3 = 8'h6F;
  localparam logic [7:0] IDW_W_NOTIFY = 8'h7F;
  localparam logic [7:0] IDW_W_SECURITY = 8'h80;
  localparam logic [7:0] IDW_W_POWER = 8'hA0;
  localparam logic [7:0] IDW_W_LAST = 8'hFE;
  localparam logic [15:0] IDW_VALID_SIG = 16'h4000;
  localparam logic [15:0] IDW_RESET_INIT = 16'h4000;
  localparam int IDW_BIT_CABLE = 13;
  localparam int IDW_BIT_U1_DIAG = 11;
  localparam int IDW_BIT_U1_METH = 9;
  localparam int IDW_BIT_U1_ONE = 8;
  localparam int IDW_BIT_U0_RESP = 6;
  localparam int IDW_BIT_U0_PRES = 5;
  localparam int IDW_BIT_U0_DIAG_PASSED_LINE = 4;
  localparam int IDW_BIT_U0_PASS = 3;
  localparam int IDW_BIT_U0_METH = 1;
  localparam int IDW_BIT_U0_ONE = 0;
  localparam int IDW_BIT_UDMA_SEL = 8;
  localparam logic [1:0] IDW_METH_RSVD = 2'h0;
  localparam logic [1:0] IDW_METH_OTHER = 2'h3;
  localparam logic [1:0] IDW_NOTIFY_YES = 2'h1;
endpackage

// >>> idw_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input is asynchronous to clk
// Notes: output follows once stages two and three agree
module idw_sync (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // pin
  input wire logic pin_in,
  output logic pin_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      pin_out <= 1'b0;
    end else if (clk_en) begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        pin_out <= s3_reg;
      end
    end
  end
endmodule // idw_sync

// >>> idw_upper.sv
// Purpose: upper identification words and the hardware reset-result word
// Assumes: word index supplied by the host read path, one word per read strobe
// Notes: reset-result capture of bits 12..0 runs only while hw_reset_active is high; the cable bit 13 tracks whenever clk_en is high
module idw_upper
  import idw_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // read port
  input wire logic rd_strobe,
  input wire logic [7:0] rd_index,
  output logic [15:0] rd_data,
  output logic rd_valid,
  // reset-result sources
  input wire logic hw_reset_active,
  input wire logic unit_one,
  input wire logic cable_detect_line,
  input wire logic diag_passed_line,
  input wire logic unit_active_present_line,
  input wire logic [1:0] unit_number_method,
  input wire logic own_diag_passed,
  input wire logic responds_for_unit_one,
  // feature and mode status
  input wire logic [13:0] feature_default_bits,
  input wire logic [6:0] udma_select_req,
  input wire logic dma_other_selected,
  input wire logic [6:0] udma_supported,
  input wire logic [7:0] acoustic_recommended,
  input wire logic [7:0] acoustic_current,
  input wire logic multi_logical,
  input wire logic long_logical,
  input wire logic [3:0] logical_ratio_log2,
  input wire logic [3:0] naming_authority_field,
  input wire logic [23:0] organization_identifier,
  input wire logic [35:0] unique_serial,
  input wire logic notify_supported,
  // security status
  input wire logic sec_level_max,
  input wire logic sec_erase_enh,
  input wire logic sec_count_expired,
  input wire logic sec_frozen,
  input wire logic sec_locked,
  input wire logic sec_enabled,
  input wire logic sec_supported,
  // card power mode
  input wire logic pwr_word_supported,
  input wire logic pwr_mode_required,
  input wire logic pwr_mode_disabled,
  input wire logic [11:0] pwr_max_current,
  // status
  output logic [15:0] reset_result,
  output logic [6:0] udma_selected
);
  logic cable_s;
  logic diag_passed_line_s;
  logic present_s;
  logic [6:0] udma_one;
  logic [15:0] reset_result_next;
  logic [15:0] word_next;
  logic present_seen_reg;
  logic diag_passed_line_seen_reg;
  logic rd_take;
  logic [15:0] wwn_last;

  idw_sync u_sync_cable (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .pin_in(cable_detect_line),
    .pin_out(cable_s)
  );

  idw_sync u_sync_diag_passed_line (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .pin_in(diag_passed_line),
    .pin_out(diag_passed_line_s)
  );

  idw_sync u_sync_present (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .pin_in(unit_active_present_line),
    .pin_out(present_s)
  );

  idw_onehot #(.N(7)) u_onehot (
    .req(udma_select_req & {7{~dma_other_selected}}),
    .sel(udma_one)
  );

  // sticky observation of partner lines during the reset sequence
  always_ff @(posedge clk) begin
    if (reset) begin
      present_seen_reg <= 1'b0;
      diag_passed_line_seen_reg <= 1'b0;
    end else if (clk_en) begin
      if (hw_reset_active) begin
        present_seen_reg <= present_seen_reg | present_s;
        diag_passed_line_seen_reg <= diag_passed_line_seen_reg | diag_passed_line_s;
      end else begin
        present_seen_reg <= 1'b0;
        diag_passed_line_seen_reg <= 1'b0;
      end
    end
  end

  // reset-result word assembly
  always_comb begin
    reset_result_next = IDW_RESET_INIT;
    reset_result_next[IDW_BIT_CABLE] = cable_s;
    if (unit_one) begin
      reset_result_next[IDW_BIT_U1_DIAG] = own_diag_passed;
      reset_result_next[IDW_BIT_U1_METH +: 2] =
        (unit_number_method == IDW_METH_RSVD) ? IDW_METH_OTHER : unit_number_method;
      reset_result_next[IDW_BIT_U1_ONE] = 1'b1;
      // low byte stays zero for unit one
    end else begin
      reset_result_next[IDW_BIT_U0_RESP] = responds_for_unit_one;
      reset_result_next[IDW_BIT_U0_PRES] = present_seen_reg | present_s;
      reset_result_next[IDW_BIT_U0_DIAG_PASSED_LINE] = diag_passed_line_seen_reg | diag_passed_line_s;
      reset_result_next[IDW_BIT_U0_PASS] = own_diag_passed;
      reset_result_next[IDW_BIT_U0_METH +: 2] =
        (unit_number_method == IDW_METH_RSVD) ? IDW_METH_OTHER : unit_number_method;
      reset_result_next[IDW_BIT_U0_ONE] = 1'b1;
      // bits 12..8 stay zero for unit zero
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reset_result <= IDW_RESET_INIT;
    end else if (clk_en) begin
      reset_result[IDW_BIT_CABLE] <= cable_s;
      if (hw_reset_active) begin
        reset_result[12:0] <= reset_result_next[12:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      udma_selected <= 7'h00;
    end else if (clk_en) begin
      udma_selected <= udma_one;
    end
  end

  // word multiplexer; reserved words read zero
  always_comb begin
    word_next = 16'h0000;
    case (rd_index)
      IDW_W_DEFAULT: word_next = IDW_VALID_SIG | {2'b00, feature_default_bits};
      IDW_W_UDMA: word_next = {1'b0, udma_selected, 1'b0, udma_supported};
      IDW_W_RESET: word_next = reset_result;
      IDW_W_ACOUSTIC: word_next = {acoustic_recommended, acoustic_current};
      IDW_W_SECTOR: word_next = IDW_VALID_SIG |
        {2'b00, multi_logical, long_logical, 8'h00, logical_ratio_log2};
      IDW_W_WWN0: word_next = {naming_authority_field, organization_identifier[23:12]};
      IDW_W_WWN1: word_next = {organization_identifier[11:0], unique_serial[35:32]};
      IDW_W_WWN2: word_next = unique_serial[31:16];
      IDW_W_WWN3: word_next = unique_serial[15:0];
      IDW_W_NOTIFY: word_next = notify_supported ? {14'h0000, IDW_NOTIFY_YES} : 16'h0000;
      IDW_W_SECURITY: word_next = {7'h00, sec_level_max, 2'b00, sec_erase_enh,
        sec_count_expired, sec_frozen, sec_locked, sec_enabled, sec_supported};
      IDW_W_POWER: word_next = {pwr_word_supported, 1'b0, pwr_mode_required,
        pwr_mode_disabled, pwr_max_current};
      default: word_next = 16'h0000;
    endcase
  end

  // one word per read strobe, presented the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= rd_strobe;
      if (rd_strobe) begin
        rd_data <= word_next;
      end
    end
  end

  // helpers for the checks below
  assign rd_take = rd_strobe & clk_en;
  assign wwn_last = unique_serial[15:0];

  at_most_one_a: assert property (@(posedge clk) disable iff (reset)
    $onehot0(udma_selected))
    else $error("several dma modes selected");

  udma_blank_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && dma_other_selected) |=> udma_selected == 7'h00)
    else $error("ultra mode kept beside another dma mode");

  udma_pick_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && !dma_other_selected && udma_select_req != 7'h00) |=> udma_selected != 7'h00)
    else $error("requested ultra mode not selected");

  low_bits_hold_a: assert property (@(posedge clk) disable iff (reset)
    (!$past(reset) && !$past(hw_reset_active) && $past(clk_en)) |-> $stable(reset_result[12:0]))
    else $error("reset result changed outside reset");

  freeze_a: assert property (@(posedge clk) disable iff (reset)
    !clk_en |=> $stable(rd_data) && $stable(rd_valid) && $stable(reset_result)
      && $stable(udma_selected))
    else $error("state moved while clock enable low");

  reset_sig_a: assert property (@(posedge clk) disable iff (reset)
    reset_result[15:14] == 2'b01)
    else $error("reset word signature wrong");

  cable_track_a: assert property (@(posedge clk) disable iff (reset)
    clk_en |=> reset_result[IDW_BIT_CABLE] == $past(cable_s))
    else $error("cable level not reported");

  unit_zero_hi_a: assert property (@(posedge clk) disable iff (reset)
    ($past(hw_reset_active) && !$past(unit_one) && $past(clk_en))
      |-> reset_result[12:8] == 5'h00 && reset_result[0])
    else $error("unit zero field wrong");

  unit_one_lo_a: assert property (@(posedge clk) disable iff (reset)
    ($past(hw_reset_active) && $past(unit_one) && $past(clk_en))
      |-> reset_result[7:0] == 8'h00 && reset_result[8])
    else $error("unit one field wrong");

  method_code_a: assert property (@(posedge clk) disable iff (reset)
    ($past(hw_reset_active) && $past(clk_en))
      |-> (reset_result[10:9] != 2'b00 || reset_result[2:1] != 2'b00))
    else $error("reserved method code");

  method_map_a: assert property (@(posedge clk) disable iff (reset)
    (hw_reset_active && clk_en && unit_number_method == IDW_METH_RSVD)
      |=> (reset_result[10:9] | reset_result[2:1]) == IDW_METH_OTHER)
    else $error("reserved method code not mapped");

  unit_one_meth_a: assert property (@(posedge clk) disable iff (reset)
    (hw_reset_active && clk_en && unit_one && unit_number_method != IDW_METH_RSVD)
      |=> reset_result[IDW_BIT_U1_METH +: 2] == $past(unit_number_method))
    else $error("unit one method code wrong");

  unit_zero_meth_a: assert property (@(posedge clk) disable iff (reset)
    (hw_reset_active && clk_en && !unit_one && unit_number_method != IDW_METH_RSVD)
      |=> reset_result[IDW_BIT_U0_METH +: 2] == $past(unit_number_method))
    else $error("unit zero method code wrong");

  unit_zero_own_a: assert property (@(posedge clk) disable iff (reset)
    (hw_reset_active && clk_en && !unit_one) |=> !reset_result[7]
      && reset_result[IDW_BIT_U0_RESP] == $past(responds_for_unit_one)
      && reset_result[IDW_BIT_U0_PASS] == $past(own_diag_passed))
    else $error("unit zero own status wrong");

  present_seen_a: assert property (@(posedge clk) disable iff (reset)
    (hw_reset_active && clk_en && !unit_one && present_s) |=> reset_result[IDW_BIT_U0_PRES])
    else $error("partner present line not recorded");

  diag_passed_line_seen_a: assert property (@(posedge clk) disable iff (reset)
    (hw_reset_active && clk_en && !unit_one && diag_passed_line_s) |=> reset_result[IDW_BIT_U0_DIAG_PASSED_LINE])
    else $error("partner diagnostics line not recorded");

  partner_quiet_a: assert property (@(posedge clk) disable iff (reset)
    (hw_reset_active && clk_en && !unit_one && !present_s && !present_seen_reg
      && !diag_passed_line_s && !diag_passed_line_seen_reg) |=> reset_result[5:4] == 2'b00)
    else $error("partner lines reported without activity");

  unit_one_diag_a: assert property (@(posedge clk) disable iff (reset)
    (hw_reset_active && clk_en && unit_one)
      |=> reset_result[IDW_BIT_U1_DIAG] == $past(own_diag_passed) && !reset_result[12])
    else $error("unit one diagnostic bit wrong");

  valid_pulse_a: assert property (@(posedge clk) disable iff (reset)
    rd_take |=> rd_valid)
    else $error("read strobe not answered");

  valid_idle_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && !rd_strobe) |=> !rd_valid)
    else $error("answer without strobe");

  data_hold_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && !rd_strobe) |=> $stable(rd_data))
    else $error("read data moved without strobe");

  read_timing_a: assert property (@(posedge clk) disable iff (reset)
    (rd_take && rd_index == IDW_W_DEFAULT) |=> rd_valid && rd_data[15:14] == 2'b01)
    else $error("default word read wrong");

  default_bits_a: assert property (@(posedge clk) disable iff (reset)
    (rd_take && rd_index == IDW_W_DEFAULT) |=> rd_data[13:0] == $past(feature_default_bits))
    else $error("default word flags wrong");

  udma_word_a: assert property (@(posedge clk) disable iff (reset)
    (rd_take && rd_index == IDW_W_UDMA) |=> !rd_data[15] && !rd_data[7]
      && rd_data[14:8] == $past(udma_selected) && rd_data[6:0] == $past(udma_supported))
    else $error("ultra dma word wrong");

  reset_word_a: assert property (@(posedge clk) disable iff (reset)
    (rd_take && rd_index == IDW_W_RESET) |=> rd_data == $past(reset_result))
    else $error("reset word read wrong");

  acoustic_word_a: assert property (@(posedge clk) disable iff (reset)
    (rd_take && rd_index == IDW_W_ACOUSTIC)
      |=> rd_data == {$past(acoustic_recommended), $past(acoustic_current)})
    else $error("acoustic word wrong");

  sector_sig_a: assert property (@(posedge clk) disable iff (reset)
    (rd_take && rd_index == IDW_W_SECTOR) |=> rd_data[15:14] == 2'b01)
    else $error("sector word signature wrong");

  sector_fields_a: assert property (@(posedge clk) disable iff (reset)
    (rd_take && rd_index == IDW_W_SECTOR) |=> rd_data[11:4] == 8'h00
      && rd_data[13] == $past(multi_logical) && rd_data[12] == $past(long_logical)
      && rd_data[3:0] == $past(logical_ratio_log2))
    else $error("sector word fields wrong");

  wwn_head_a: assert property (@(posedge clk) disable iff (reset)
    (rd_take && rd_index == IDW_W_WWN0) |=> rd_data[15:12] == $past(naming_authority_field))
    else $error("name does not open with authority field");

  wwn_tail_a: assert property (@(posedge clk) disable iff (reset)
    (rd_take && rd_index == IDW_W_WWN3) |=> rd_data == $past(wwn_last))
    else $error("name does not close with low serial bits");

  notify_code_a: assert property (@(posedge clk) disable iff (reset)
    (rd_take && rd_index == IDW_W_NOTIFY)
      |=> rd_data[15:2] == 14'h0000 && rd_data[1:0] == {1'b0, $past(notify_supported)})
    else $error("notify code reserved");

  security_word_a: assert property (@(posedge clk) disable iff (reset)
    (rd_take && rd_index == IDW_W_SECURITY) |=> rd_data[15:9] == 7'h00
      && rd_data[7:6] == 2'b00 && rd_data[8] == $past(sec_level_max) && rd_data[0] == $past(sec_supported)
      && rd_data[5] == $past(sec_erase_enh) && rd_data[4] == $past(sec_count_expired))
    else $error("security word wrong");

  security_state_a: assert property (@(posedge clk) disable iff (reset)
    (rd_take && rd_index == IDW_W_SECURITY)
      |=> rd_data[3:1] == {$past(sec_frozen), $past(sec_locked), $past(sec_enabled)})
    else $error("security state bits wrong");

  power_word_a: assert property (@(posedge clk) disable iff (reset)
    (rd_take && rd_index == IDW_W_POWER) |=> rd_data[15] == $past(pwr_word_supported)
      && !rd_data[14] && rd_data[13] == $past(pwr_mode_required)
      && rd_data[12] == $past(pwr_mode_disabled) && rd_data[11:0] == $past(pwr_max_current))
    else $error("power mode word wrong");

  low_words_a: assert property (@(posedge clk) disable iff (reset)
    (rd_take && rd_index < IDW_W_DEFAULT) |=> rd_data == 16'h0000)
    else $error("lower word not zero");

  gap_words_a: assert property (@(posedge clk) disable iff (reset)
    (rd_take && rd_index > IDW_W_UDMA && rd_index < IDW_W_RESET) |=> rd_data == 16'h0000)
    else $error("gap word not zero");

  unused_word_a: assert property (@(posedge clk) disable iff (reset)
    (rd_take && rd_index > IDW_W_POWER) |=> rd_data == 16'h0000)
    else $error("reserved word not zero");
endmodule // idw_upper

// >>> idw_upper_tb.sv
// Purpose: self-checking bench for the upper identification words
// Assumes: host model fetches words in ascending order
// Notes: reset-result inputs settle before each capture window
module idw_upper_tb
  import idw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, reset, clk_en, rd_strobe, rd_valid, hw_reset_active, unit_one;
  logic cable_detect_line, diag_passed_line, unit_active_present_line;
  logic own_diag_passed, responds_for_unit_one, dma_other_selected;
  logic multi_logical, long_logical, notify_supported;
  logic sec_level_max, sec_erase_enh, sec_count_expired, sec_frozen, sec_locked;
  logic sec_enabled, sec_supported, pwr_word_supported, pwr_mode_required, pwr_mode_disabled;
  logic [1:0] unit_number_method;
  logic [3:0] logical_ratio_log2, naming_authority_field;
  logic [6:0] udma_select_req, udma_supported, udma_selected;
  logic [7:0] rd_index, acoustic_recommended, acoustic_current;
  logic [11:0] pwr_max_current;
  logic [13:0] feature_default_bits;
  logic [15:0] rd_data, reset_result;
  logic [23:0] organization_identifier;
  logic [35:0] unique_serial;
  int fail_count = 0;
  int n_tests = 0;
  logic [7:0] idx_t [15] = '{8'h00, 8'h57, 8'h58, 8'h59, 8'h5E, 8'h69, 8'h6A, 8'h6C, 8'h6D,
    8'h6E, 8'h6F, 8'h7F, 8'h80, 8'hA0, 8'hFE};
  logic [15:0] exp_t [15] = '{16'h0000, 16'h6A5C, 16'h101F, 16'h0000, 16'hC35A, 16'h0000,
    16'h6003, 16'h5A1B, 16'h2C39, 16'h8765, 16'h4321, 16'h0001, 16'h0115, 16'h9ABC, 16'h0000};

  idw_upper DUT (.clk, .reset, .clk_en, .rd_strobe, .rd_index, .rd_data, .rd_valid,
    .hw_reset_active, .unit_one, .cable_detect_line, .diag_passed_line,
    .unit_active_present_line, .unit_number_method, .own_diag_passed, .responds_for_unit_one,
    .feature_default_bits, .udma_select_req, .dma_other_selected, .udma_supported,
    .acoustic_recommended, .acoustic_current, .multi_logical, .long_logical,
    .logical_ratio_log2, .naming_authority_field, .organization_identifier, .unique_serial,
    .notify_supported, .sec_level_max, .sec_erase_enh, .sec_count_expired, .sec_frozen,
    .sec_locked, .sec_enabled, .sec_supported, .pwr_word_supported, .pwr_mode_required,
    .pwr_mode_disabled, .pwr_max_current, .reset_result, .udma_selected);

  idw_host_model host (.clk, .rd_strobe, .rd_index, .rd_data, .rd_valid);

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
      fail_count++;
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // v = {unit, cable, diag, present, own pass, responds, method}
  task automatic capture(input logic [7:0] v, input bit pulse, input logic [15:0] e);
    logic [15:0] d;
    bit ok;
    @(posedge clk);
    {unit_one, cable_detect_line, diag_passed_line, unit_active_present_line,
      own_diag_passed, responds_for_unit_one, unit_number_method} <= v;
    repeat (6) @(posedge clk);
    hw_reset_active <= pulse;
    repeat (8) @(posedge clk);
    hw_reset_active <= 1'b0;
    host.read_word(IDW_W_RESET, d, ok);
    check({15'h0, ok}, 16'h0001, "no answer");
    check(d, e, "reset word");
  endtask

  task automatic words_check();
    logic [15:0] d;
    bit ok;
    for (int i = 0; i < 15; i++) begin
      host.read_word(idx_t[i], d, ok);
      check({15'h0, ok}, 16'h0001, "id answer");
      check(d, exp_t[i], "id word");
    end
  endtask

  task automatic udma_check();
    logic [15:0] d;
    bit ok;
    @(posedge clk);
    udma_select_req <= 7'h60;
    repeat (3) @(posedge clk);
    #1;
    check({9'h0, udma_selected}, 16'h0020, "lowest mode");
    @(posedge clk);
    dma_other_selected <= 1'b1;
    host.read_word(IDW_W_UDMA, d, ok);
    check(d, 16'h001F, "other dma");
    check({9'h0, udma_selected}, 16'h0000, "blanked mode");
  endtask

  // clock enable low: strobe ignored, cable change held back until enabled
  task automatic freeze_check();
    logic [15:0] d;
    bit ok;
    @(posedge clk);
    clk_en <= 1'b0;
    cable_detect_line <= 1'b1;
    host.read_word(IDW_W_SECURITY, d, ok);
    check({15'h0, ok}, 16'h0000, "frozen answer");
    check(rd_data, 16'h001F, "frozen data");
    check(reset_result, 16'h4700, "frozen reset word");
    @(posedge clk);
    clk_en <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check(reset_result, 16'h6700, "cable level");
    host.read_word(IDW_W_RESET, d, ok);
    check(d, 16'h6700, "reset word after freeze");
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    final_report();
  end

  initial begin
    {hw_reset_active, unit_one, cable_detect_line, diag_passed_line, unit_active_present_line,
      own_diag_passed, responds_for_unit_one, unit_number_method, dma_other_selected} = '0;
    {sec_level_max, sec_erase_enh, sec_count_expired, sec_frozen} = 4'b1010;
    {sec_locked, sec_enabled, sec_supported, notify_supported} = 4'b1011;
    {pwr_word_supported, pwr_mode_required, pwr_mode_disabled} = 3'b101;
    {multi_logical, long_logical, logical_ratio_log2} = 6'h23;
    pwr_max_current = 12'hABC;
    feature_default_bits = 14'h2A5C;
    udma_select_req = 7'h10;
    udma_supported = 7'h1F;
    acoustic_recommended = 8'hC3;
    acoustic_current = 8'h5A;
    naming_authority_field = 4'h5;
    organization_identifier = 24'hA1_B2C3;
    unique_serial = 36'h9_8765_4321;
    clk_en = 1'b1;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    check(reset_result, 16'h4000, "reset value");
    capture(8'b0111_1101, 1'b1, 16'h607B);
    capture(8'b0000_0010, 1'b0, 16'h407B);
    capture(8'b0000_0010, 1'b1, 16'h4005);
    capture(8'b0000_0011, 1'b1, 16'h4007);
    capture(8'b1011_1110, 1'b1, 16'h4D00);
    capture(8'b1101_1101, 1'b1, 16'h6B00);
    capture(8'b1000_0000, 1'b1, 16'h4700);
    words_check();
    udma_check();
    freeze_check();
    final_report();
  end
endmodule // idw_upper_tb
